// File: shared/aimcr_pkg.sv
package aimcr_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFF_IRQ_STATUS     = 8'h18;
    localparam logic [7:0]  OFF_IRQ_CLEAR      = 8'h1C;
    localparam logic [7:0]  OFF_IRQ_ENABLE_SET = 8'h20;
    localparam logic [7:0]  OFF_IRQ_DISABLE    = 8'h24;
    localparam logic [7:0]  OFF_IRQ_MASK       = 8'h28;
    localparam logic [7:0]  OFF_LAST_RESULT    = 8'h2C;
    localparam logic [7:0]  OFF_CHAN_IMPL      = 8'h30;
    localparam logic [7:0]  OFF_VERSION        = 8'h34;
    localparam logic [7:0]  OFF_CHAN_EN_SET    = 8'h40;
    localparam logic [7:0]  OFF_CHAN_EN_CLEAR  = 8'h44;
    localparam logic [7:0]  OFF_CHAN_EN_STATE  = 8'h48;

    // ----------------------------------------------------------------
    // Interrupt bit positions
    // ----------------------------------------------------------------
    localparam int          BIT_DATA_READY     = 0;
    localparam int          BIT_OVERRUN        = 1;
    localparam int          BIT_PEN_CONTACT    = 4;
    localparam int          BIT_CONTACT_LOST   = 5;
    localparam int          BIT_READY          = 8;
    localparam int          BIT_BUSY           = 9;
    localparam int          BIT_COMPARE_BELOW  = 12;
    localparam int          BIT_COMPARE_ABOVE  = 13;
    localparam int          BIT_COMPARE_INSIDE = 14;
    localparam logic [31:0] IRQ_USED_MASK      = 32'h0000_7333;

    // ----------------------------------------------------------------
    // Result and version register layout
    // ----------------------------------------------------------------
    localparam int          RESULT_VALUE_LSB   = 0;
    localparam int          RESULT_TAG_LSB     = 16;
    localparam int          RESULT_TAG_W       = 8;
    localparam int          VERSION_VARIANT_LSB = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_IRQ_MASK       = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_STATUS     = 32'h0000_0000;
    localparam logic [31:0] RST_LAST_RESULT    = 32'h0000_0000;
    localparam logic [31:0] RST_CHAN_EN_STATE  = 32'h0000_0000;
    localparam logic [31:0] RST_PRDATA         = 32'h0000_0000;

endpackage : aimcr_pkg

// File: hdl/aimcr_regs.sv
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module aimcr_regs
    import aimcr_pkg::*;
#(
    parameter logic [31:0] CHAN_IMPL   = 32'h0000_03FF,
    parameter logic [11:0] VERSION_NUM = 12'h0A5,   // Arbitrary value
    parameter logic [3:0]  VARIANT_NUM = 4'h0,      // Arbitrary value
    parameter int          RESULT_W    = 12
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Conversion engine
    input  wire logic                convDone,
    input  wire logic [RESULT_W-1:0] convValue,
    input  wire logic [4:0]          convChannel,
    input  wire logic [31:0]         statusLevels,
    // Sequencer and interrupt
    output logic      [31:0]         channelEnable,
    output logic                     irq
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (RESULT_W < 1 || RESULT_W > 12) begin : g_bad_width
        $error("aimcr_regs: RESULT_W must be 1 to 12");
    end
    if (CHAN_IMPL == 32'h0000_0000) begin : g_bad_impl
        $error("aimcr_regs: at least one channel must be implemented");
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic        setupPhase;
    logic        writeStrobe;
    logic [31:0] wrData;
    logic        hitMapped;

    assign setupPhase  = psel & ~penable;
    // Writes land only at the access edge, once per transfer
    assign writeStrobe = psel & penable & pwrite;
    assign wrData      = pwdata;
    // Zero wait states: read data was captured in the setup cycle
    assign pready      = 1'b1;

    always_comb begin
        unique case (paddr)
            OFF_IRQ_STATUS, OFF_IRQ_CLEAR, OFF_IRQ_ENABLE_SET, OFF_IRQ_DISABLE,
            OFF_IRQ_MASK, OFF_LAST_RESULT, OFF_CHAN_IMPL, OFF_VERSION,
            OFF_CHAN_EN_SET, OFF_CHAN_EN_CLEAR, OFF_CHAN_EN_STATE: begin
                hitMapped = 1'b1;
            end
            default: begin
                hitMapped = 1'b0;
            end
        endcase
    end

    logic wrClear;
    logic wrEnableSet;
    logic wrDisable;
    logic wrChanSet;
    logic wrChanClear;

    assign wrClear     = writeStrobe && (paddr == OFF_IRQ_CLEAR);
    assign wrEnableSet = writeStrobe && (paddr == OFF_IRQ_ENABLE_SET);
    assign wrDisable   = writeStrobe && (paddr == OFF_IRQ_DISABLE);
    assign wrChanSet   = writeStrobe && (paddr == OFF_CHAN_EN_SET);
    assign wrChanClear = writeStrobe && (paddr == OFF_CHAN_EN_CLEAR);

    // ----------------------------------------------------------------
    // Interrupt mask
    // ----------------------------------------------------------------
    logic [31:0] irqMask;
    logic [31:0] next_irqMask;

    always_comb begin
        next_irqMask = irqMask;
        if (wrEnableSet) begin
            next_irqMask = next_irqMask | (wrData & IRQ_USED_MASK);
        end
        if (wrDisable) begin
            next_irqMask = next_irqMask & ~(wrData & IRQ_USED_MASK);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqMask <= RST_IRQ_MASK;
        end else begin
            irqMask <= next_irqMask;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    logic [31:0] irqStatus;
    logic [31:0] next_irqStatus;
    logic [31:0] levelPrev;
    logic [31:0] next_levelPrev;
    logic [31:0] irqEvents;

    always_comb begin
        // Level flags raise an event on their rising edge only
        irqEvents                 = statusLevels & ~levelPrev & IRQ_USED_MASK;
        // Data ready fires on every completion, even if already high
        irqEvents[BIT_DATA_READY] = convDone;
        next_levelPrev            = statusLevels;
        next_irqStatus            = irqStatus;
        if (wrClear) begin
            next_irqStatus = next_irqStatus & ~wrData;
        end
        // Set wins over a clear in the same cycle, so no event is lost
        next_irqStatus = next_irqStatus | irqEvents;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus <= RST_IRQ_STATUS;
            levelPrev <= RST_IRQ_STATUS;
        end else begin
            irqStatus <= next_irqStatus;
            levelPrev <= next_levelPrev;
        end
    end

    logic next_irq;

    assign next_irq = |(next_irqStatus & next_irqMask);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // Last converted result
    // ----------------------------------------------------------------
    logic [RESULT_W-1:0]     resultValue;
    logic [RESULT_W-1:0]     next_resultValue;
    logic [RESULT_TAG_W-1:0] resultChannelTag;
    logic [RESULT_TAG_W-1:0] next_resultChannelTag;

    always_comb begin
        next_resultValue      = resultValue;
        next_resultChannelTag = resultChannelTag;
        // Loaded whatever the channel state; a channel toggled mid-conversion
        // simply leaves whatever the engine delivered
        if (convDone) begin
            next_resultValue      = convValue;
            next_resultChannelTag = {3'h0, convChannel};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resultValue      <= RST_LAST_RESULT[RESULT_W-1:0];
            resultChannelTag <= RST_LAST_RESULT[RESULT_TAG_W-1:0];
        end else begin
            resultValue      <= next_resultValue;
            resultChannelTag <= next_resultChannelTag;
        end
    end

    // ----------------------------------------------------------------
    // Channel enables
    // ----------------------------------------------------------------
    logic [31:0] next_channelEnable;

    always_comb begin
        next_channelEnable = channelEnable;
        if (wrChanSet) begin
            next_channelEnable = next_channelEnable | wrData;
        end
        if (wrChanClear) begin
            next_channelEnable = next_channelEnable & ~wrData;
        end
        // Positions without a channel never hold state
        next_channelEnable = next_channelEnable & CHAN_IMPL;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            channelEnable <= RST_CHAN_EN_STATE;
        end else begin
            channelEnable <= next_channelEnable;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [31:0] readMux;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        readMux = 32'h0000_0000;
        unique case (paddr)
            OFF_IRQ_STATUS: begin
                readMux = irqStatus & IRQ_USED_MASK;
            end
            OFF_IRQ_MASK: begin
                readMux = irqMask & IRQ_USED_MASK;
            end
            OFF_LAST_RESULT: begin
                readMux[RESULT_VALUE_LSB +: RESULT_W]   = resultValue;
                readMux[RESULT_TAG_LSB +: RESULT_TAG_W] = resultChannelTag;
            end
            OFF_CHAN_IMPL: begin
                readMux = CHAN_IMPL;
            end
            OFF_VERSION: begin
                readMux[11:0]                     = VERSION_NUM;
                readMux[VERSION_VARIANT_LSB +: 4] = VARIANT_NUM;
            end
            OFF_CHAN_EN_STATE: begin
                readMux = channelEnable;
            end
            default: begin
                // Write-only and unmapped words read as zero
                readMux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setupPhase) begin
            next_prdata  = pwrite ? 32'h0000_0000 : readMux;
            next_pslverr = ~hitMapped;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= RST_PRDATA;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule : aimcr_regs

// File: test/aimcr_regs_checker.sv
`timescale 1ns/10ps
module aimcr_regs_checker
    import aimcr_pkg::*;
#(
    parameter logic [31:0] CHAN_IMPL   = 32'h0000_03FF,
    parameter logic [11:0] VERSION_NUM = 12'h0A5,
    parameter logic [3:0]  VARIANT_NUM = 4'h0,
    parameter int          RESULT_W    = 12
) (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_b,
    // APB slave
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [DATA_W-1:0]   pwdata,
    input wire logic [DATA_W-1:0]   prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Conversion engine
    input wire logic                convDone,
    input wire logic [RESULT_W-1:0] convValue,
    input wire logic [4:0]          convChannel,
    input wire logic [31:0]         statusLevels,
    // Sequencer and interrupt
    input wire logic [31:0]         channelEnable,
    input wire logic                irq
);
    // ----------------------------------------------------------------
    // Bus phases
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_write(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_read(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    a_chan_set: assert property (s_write(OFF_CHAN_EN_SET) |=>
        (channelEnable & $past(pwdata) & CHAN_IMPL) == ($past(pwdata) & CHAN_IMPL))
        else $error("channel enable write missed a bit");
    a_chan_keep: assert property (s_write(OFF_CHAN_EN_SET) |=>
        (channelEnable & ~$past(pwdata)) == ($past(channelEnable) & ~$past(pwdata)))
        else $error("channel enable write changed a zero bit");
    a_chan_clear: assert property (s_write(OFF_CHAN_EN_CLEAR) |=>
        (channelEnable & $past(pwdata)) == 32'h0000_0000)
        else $error("channel disable write missed a bit");
    a_chan_impl: assert property ((channelEnable & ~CHAN_IMPL) == 32'h0000_0000)
        else $error("absent channel enabled");
    a_state_read: assert property (s_read(OFF_CHAN_EN_STATE) |=> prdata == channelEnable)
        else $error("channel state read wrong");
    a_mask_reserved: assert property (s_read(OFF_IRQ_MASK) |=>
        (prdata & ~IRQ_USED_MASK) == 32'h0000_0000)
        else $error("reserved mask bit reads one");
    a_impl_read: assert property (s_read(OFF_CHAN_IMPL) |=> prdata == CHAN_IMPL)
        else $error("implemented channel read wrong");
    a_version_read: assert property (s_read(OFF_VERSION) |=>
        prdata[11:0] == VERSION_NUM && prdata[19:16] == VARIANT_NUM)
        else $error("version read wrong");
    a_mask_off_quiet: assert property (s_write(OFF_IRQ_DISABLE)
        && (pwdata & IRQ_USED_MASK) == IRQ_USED_MASK |=> !irq)
        else $error("irq high with all sources masked");
    a_clear_quiet: assert property (s_write(OFF_IRQ_CLEAR) && pwdata == 32'hFFFF_FFFF
        && !convDone && $stable(statusLevels) |=> !irq)
        else $error("irq high after full clear");
endmodule : aimcr_regs_checker

bind aimcr_regs aimcr_regs_checker #(.CHAN_IMPL(CHAN_IMPL), .VERSION_NUM(VERSION_NUM),
    .VARIANT_NUM(VARIANT_NUM), .RESULT_W(RESULT_W)) aimcr_regs_checker_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convDone(convDone), .convValue(convValue), .convChannel(convChannel),
    .statusLevels(statusLevels), .channelEnable(channelEnable), .irq(irq));

// File: test/tb_aimcr_regs.sv
`timescale 1ns/10ps
module tb_aimcr_regs
    import aimcr_pkg::*;
;
    localparam logic [31:0] IMPL = 32'h0000_03FF;
    localparam logic [11:0] VERN = 12'h0A5;  // Arbitrary value
    localparam logic [3:0]  VARN = 4'h3;     // Arbitrary value
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} aimcr_row_t;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, convDone, irq, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, statusLevels, channelEnable, rdata;
    logic [11:0] convValue;
    logic [4:0]  convChannel;
    int          failures, check_count, cycles;
    aimcr_row_t  rows [11] = '{
        '{OFF_IRQ_ENABLE_SET, 32'hFFFF_FFFF, OFF_IRQ_MASK, IRQ_USED_MASK},
        '{OFF_IRQ_DISABLE, 32'h0000_0003, OFF_IRQ_MASK, 32'h0000_7330},
        '{OFF_IRQ_DISABLE, 32'h0000_0000, OFF_IRQ_MASK, 32'h0000_7330},
        '{OFF_IRQ_MASK, 32'hFFFF_FFFF, OFF_IRQ_MASK, 32'h0000_7330},
        '{OFF_CHAN_EN_SET, 32'hFFFF_FFFF, OFF_CHAN_EN_STATE, IMPL},
        '{OFF_CHAN_EN_CLEAR, 32'h0000_0005, OFF_CHAN_EN_STATE, 32'h0000_03FA},
        '{OFF_CHAN_EN_SET, 32'h0000_0000, OFF_CHAN_EN_STATE, 32'h0000_03FA},
        '{OFF_CHAN_EN_CLEAR, 32'hFFFF_FFFF, OFF_CHAN_EN_STATE, 32'h0000_0000},
        '{OFF_CHAN_IMPL, 32'h0000_0000, OFF_CHAN_IMPL, IMPL},
        '{OFF_VERSION, 32'h0000_0000, OFF_VERSION, {12'h000, VARN, 4'h0, VERN}},
        '{OFF_IRQ_DISABLE, 32'hFFFF_FFFF, OFF_IRQ_MASK, 32'h0000_0000}};

    aimcr_regs #(.CHAN_IMPL(IMPL), .VERSION_NUM(VERN), .VARIANT_NUM(VARN), .RESULT_W(12))
    aimcr_regs_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convDone(convDone), .convValue(convValue),
        .convChannel(convChannel), .statusLevels(statusLevels),
        .channelEnable(channelEnable), .irq(irq));

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch
        check_count++;
        if (pready !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %0t: no ready on bus", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task check32(input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            failures++;
            $display("CHECK FAILED %0t: word want %h got %h", $time, ex, got);
        end
    endtask : check32
    task checkBit(input logic ex, input logic got);
        check_count++;
        if (got !== ex) begin
            failures++;
            $display("CHECK FAILED %0t: bit want %b got %b", $time, ex, got);
        end
    endtask : checkBit
    task conv(input logic [11:0] v, input logic [4:0] c, input logic on);
        @(posedge clk_sys);
        convDone <= on; convValue <= v; convChannel <= c;
    endtask : conv
    task print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Generous ceiling; the whole run needs well under two hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; convDone = 1'b0; convValue = 12'h0; convChannel = 5'h0;
        statusLevels = 32'h0; failures = 0; check_count = 0; cycles = 0;
        repeat (20) @(posedge clk_sys);
        check32(RST_CHAN_EN_STATE, channelEnable);
        rst_b <= 1'b1;
        apb(1'b0, OFF_IRQ_MASK, 32'h0); check32(RST_IRQ_MASK, rdata);
        apb(1'b0, OFF_LAST_RESULT, 32'h0); check32(RST_LAST_RESULT, rdata);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].wa, rows[i].wd);
            apb(1'b0, rows[i].ra, 32'h0); check32(rows[i].ex, rdata);
        end
        $display("table test done");
        // Back-to-back results: only the second may survive
        conv(12'hABC, 5'd9, 1'b1); conv(12'h123, 5'd4, 1'b1); conv(12'h000, 5'd0, 1'b0);
        apb(1'b0, OFF_LAST_RESULT, 32'h0); check32(32'h0004_0123, rdata);
        apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h0000_2001); #1 checkBit(1'b1, irq);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001); #1 checkBit(1'b0, irq);
        @(posedge clk_sys) statusLevels <= 32'h0000_3000;
        @(posedge clk_sys) #1 checkBit(1'b1, irq);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0); check32(32'h0000_3000, rdata);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h0000_2000); #1 checkBit(1'b0, irq);
        apb(1'b1, OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0); check32(32'h0, rdata);
        apb(1'b1, 8'h50, 32'hFFFF_FFFF); checkBit(1'b1, rerr);
        apb(1'b0, 8'h50, 32'h0); check32(32'h0, rdata);
        $display("interrupt test done");
        // Reset in mid-run drops channel state
        apb(1'b1, OFF_CHAN_EN_SET, 32'h0000_0010); #1 check32(32'h0000_0010, channelEnable);
        @(posedge clk_sys) rst_b <= 1'b0;
        @(posedge clk_sys) #1 check32(32'h0, channelEnable);
        @(posedge clk_sys) rst_b <= 1'b1;
        @(posedge clk_sys) #1 check32(32'h0, channelEnable);
        $display("second reset test done");
        print_verdict();
    end
endmodule : tb_aimcr_regs
